/* src/swc_defines.vh */
`ifndef SWC_DEFINES_VH
`define SWC_DEFINES_VH

// Command codes
`define SWC_CMD_WRITE_CFG 8'hD2
`define SWC_CMD_BUS_RESET 8'hB4

// Status register bit positions
`define SWC_ST_BUSY 0
`define SWC_ST_PRESENCE 1
`define SWC_ST_SHORT 2
`define SWC_ST_LEVEL 3
`define SWC_ST_DEVRST 4

// Configuration register bit positions
`define SWC_CFG_APU 0
`define SWC_CFG_PPM 1
`define SWC_CFG_SPU 2
`define SWC_CFG_OD 3
`define SWC_CFG_RESET 4'h0

// Read pointer codes
`define SWC_PTR_STATUS 1'b0
`define SWC_PTR_CONFIG 1'b1

// Clock period and line times, in ns
`define SWC_CLK_NS 8
`define SWC_RSTL_STD_NS 560000
`define SWC_RSTH_STD_NS 560000
`define SWC_SI_STD_NS 8000
`define SWC_MSP_STD_NS 68000
`define SWC_RSTL_OD_NS 70000
`define SWC_RSTH_OD_NS 70000
`define SWC_SI_OD_NS 1000
`define SWC_MSP_OD_NS 8000
`define SWC_APU_NS 250

// Least times round up to whole cycles
`define SWC_CYC(ns) (((ns) + `SWC_CLK_NS - 1) / `SWC_CLK_NS)

`endif

/* src/swc_sync.v */
`timescale 1ns/1ps
`include "swc_defines.vh"

module swc_sync #(
  parameter WIDTH = 3
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [WIDTH-1:0] i_d,
  output reg [WIDTH-1:0] o_q
);

  reg [WIDTH-1:0] stage1_reg;

  // Two flops; the first one feeds only the second
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage1_reg <= {WIDTH{1'b1}};
      o_q <= {WIDTH{1'b1}};
    end else begin
      stage1_reg <= i_d;
      o_q <= stage1_reg;
    end
  end

endmodule // swc_sync

/* src/swc_cmd.v */
// How it works
// [RULE_01] Code D2h plus one byte writes configuration
// [RULE_02] Accept byte only if high nibble inverts low
// [RULE_03] Configuration reads return zero upper nibble
// [RULE_04] Load configuration at parameter acknowledge rising SCL
// [RULE_05] Busy at code: nack code, parameter, discard
// [RULE_06] Configuration write points reads at configuration
// [RULE_07] Write updates speed, strong, mask, active pullup
// [RULE_08] Configuration write clears device-reset flag
// [RULE_09] Code B4h starts line reset cycle
// [RULE_10] Busy at reset code: nack and ignore
// [RULE_11] Cycle ends within low plus high plus 262.5ns
// [RULE_12] Line activity starts within 262.5ns
// [RULE_13] Sample short and presence after low period
// [RULE_14] Accepted reset points reads at status
// [RULE_15] Cycle follows speed, mask, active pullup settings
// [RULE_16] Busy flag held for low plus high
// [RULE_17] Host polls busy before next command
`timescale 1ns/1ps
`include "swc_defines.vh"

module swc_cmd #(
  parameter [6:0] P_SLAVE_ADDR = 7'h2A,
  parameter [19:0] P_RSTL_STD_CYC = `SWC_CYC(`SWC_RSTL_STD_NS),
  parameter [19:0] P_RSTH_STD_CYC = `SWC_CYC(`SWC_RSTH_STD_NS),
  parameter [19:0] P_SI_STD_CYC = `SWC_CYC(`SWC_SI_STD_NS),
  parameter [19:0] P_MSP_STD_CYC = `SWC_CYC(`SWC_MSP_STD_NS),
  parameter [19:0] P_RSTL_OD_CYC = `SWC_CYC(`SWC_RSTL_OD_NS),
  parameter [19:0] P_RSTH_OD_CYC = `SWC_CYC(`SWC_RSTH_OD_NS),
  parameter [19:0] P_SI_OD_CYC = `SWC_CYC(`SWC_SI_OD_NS),
  parameter [19:0] P_MSP_OD_CYC = `SWC_CYC(`SWC_MSP_OD_NS),
  parameter [19:0] P_APU_CYC = `SWC_CYC(`SWC_APU_NS)
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_scl,
  input wire i_sda,
  output reg o_sda_out,
  output reg o_sda_oe,
  input wire i_line,
  output reg o_line_out,
  output reg o_line_oe
);

  localparam [6:0] S_IDLE = 7'b000_0001;
  localparam [6:0] S_ADDR = 7'b000_0010;
  localparam [6:0] S_AACK = 7'b000_0100;
  localparam [6:0] S_WRB = 7'b000_1000;
  localparam [6:0] S_WACK = 7'b001_0000;
  localparam [6:0] S_RDB = 7'b010_0000;
  localparam [6:0] S_RACK = 7'b100_0000;

  wire [2:0] sync_q;
  wire scl_s;
  wire sda_s;
  wire line_s;
  reg scl_d_reg;
  reg sda_d_reg;
  reg [6:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] cmd_reg;
  reg [1:0] byte_idx_reg;
  reg ack_reg;
  reg ack_on_reg;
  reg rw_reg;
  reg discard_reg;
  reg macked_reg;
  reg ptr_reg;
  reg [3:0] cfg_reg;
  reg devrst_reg;
  reg go_reg;
  reg busy_reg;
  reg low_reg;
  reg high_reg;
  reg ppd_reg;
  reg sd_reg;
  reg [19:0] cnt_reg;
  wire [7:0] byte_in;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire cfg_ok;
  wire od;
  wire [19:0] rstl_cyc;
  wire [19:0] rsth_cyc;
  wire [19:0] si_cyc;
  wire [19:0] msp_cyc;
  wire [7:0] rd_byte;

  swc_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_d({i_line, i_sda, i_scl}),
    .o_q(sync_q)
  );

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign line_s = sync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions and register read value

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign byte_in = {shift_reg[6:0], sda_s};
  assign cfg_ok = (byte_in[7:4] == ~byte_in[3:0]); // [RULE_02]

  function [7:0] read_value;
    input ptr;
    input [3:0] cfg;
    input [4:0] st;
    begin
      if (ptr == `SWC_PTR_CONFIG) begin
        read_value = {4'h0, cfg}; // [RULE_03]
      end else begin
        read_value = {3'h0, st};
      end
    end
  endfunction

  assign rd_byte = read_value(ptr_reg, cfg_reg, {devrst_reg, line_s, sd_reg, ppd_reg, busy_reg});

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave and command decode

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= S_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      ack_reg <= 1'b0;
      ack_on_reg <= 1'b0;
      rw_reg <= 1'b0;
      discard_reg <= 1'b0;
      macked_reg <= 1'b0;
      ptr_reg <= `SWC_PTR_STATUS;
      cfg_reg <= `SWC_CFG_RESET;
      devrst_reg <= 1'b1;
      go_reg <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      go_reg <= 1'b0;
      if (start_cond) begin
        state_reg <= S_ADDR;
        bit_cnt_reg <= 3'h0;
        ack_on_reg <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          S_ADDR: begin
            if (scl_rise) begin
              shift_reg <= byte_in;
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7) begin
                ack_reg <= (byte_in[7:1] == P_SLAVE_ADDR);
                rw_reg <= byte_in[0];
                byte_idx_reg <= 2'h0;
                discard_reg <= 1'b0;
                state_reg <= S_AACK;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              if (!ack_on_reg) begin
                ack_on_reg <= 1'b1;
                o_sda_oe <= ack_reg;
              end else begin
                ack_on_reg <= 1'b0;
                bit_cnt_reg <= 3'h0;
                if (!ack_reg) begin
                  o_sda_oe <= 1'b0;
                  state_reg <= S_IDLE;
                end else if (rw_reg) begin
                  o_sda_oe <= ~rd_byte[7];
                  shift_reg <= {rd_byte[6:0], 1'b0};
                  bit_cnt_reg <= 3'h1;
                  state_reg <= S_RDB;
                end else begin
                  o_sda_oe <= 1'b0;
                  state_reg <= S_WRB;
                end
              end
            end
          end
          S_WRB: begin
            if (scl_rise) begin
              shift_reg <= byte_in;
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7) begin
                state_reg <= S_WACK;
                if (byte_idx_reg == 2'h0) begin
                  cmd_reg <= byte_in;
                  if (byte_in == `SWC_CMD_WRITE_CFG) begin // [RULE_01]
                    ack_reg <= ~busy_reg; // [RULE_05]
                    discard_reg <= busy_reg; // [RULE_05]
                  end else if (byte_in == `SWC_CMD_BUS_RESET) begin // [RULE_09]
                    ack_reg <= ~busy_reg; // [RULE_10]
                    discard_reg <= busy_reg; // [RULE_10]
                  end else begin
                    ack_reg <= 1'b0;
                    discard_reg <= 1'b1;
                  end
                end else begin
                  ack_reg <= (byte_idx_reg == 2'h1) && !discard_reg &&
                             (cmd_reg == `SWC_CMD_WRITE_CFG) && cfg_ok; // [RULE_02] [RULE_05]
                end
              end
            end
          end
          S_WACK: begin
            if (scl_rise && ack_on_reg && ack_reg && (byte_idx_reg == 2'h1)) begin
              cfg_reg <= shift_reg[3:0]; // [RULE_04] [RULE_07]
              devrst_reg <= 1'b0; // [RULE_08]
              ptr_reg <= `SWC_PTR_CONFIG; // [RULE_06]
            end
            if (scl_fall) begin
              if (!ack_on_reg) begin
                ack_on_reg <= 1'b1;
                o_sda_oe <= ack_reg;
              end else begin
                ack_on_reg <= 1'b0;
                o_sda_oe <= 1'b0;
                bit_cnt_reg <= 3'h0;
                state_reg <= S_WRB;
                if (byte_idx_reg != 2'h2) begin
                  byte_idx_reg <= byte_idx_reg + 2'h1;
                end
                if (ack_reg && (byte_idx_reg == 2'h0) && (cmd_reg == `SWC_CMD_BUS_RESET)) begin
                  go_reg <= 1'b1; // [RULE_12]
                  ptr_reg <= `SWC_PTR_STATUS; // [RULE_14]
                end
              end
            end
          end
          S_RDB: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 3'h0) begin
                o_sda_oe <= 1'b0;
                state_reg <= S_RACK;
              end else begin
                o_sda_oe <= ~shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              macked_reg <= ~sda_s;
            end
            if (scl_fall) begin
              if (macked_reg) begin
                o_sda_oe <= ~rd_byte[7];
                shift_reg <= {rd_byte[6:0], 1'b0};
                bit_cnt_reg <= 3'h1;
                state_reg <= S_RDB;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line reset and presence-detect cycle

  assign od = cfg_reg[`SWC_CFG_OD];
  assign rstl_cyc = od ? P_RSTL_OD_CYC : P_RSTL_STD_CYC; // [RULE_15]
  assign rsth_cyc = od ? P_RSTH_OD_CYC : P_RSTH_STD_CYC; // [RULE_15]
  assign si_cyc = od ? P_SI_OD_CYC : P_SI_STD_CYC;
  assign msp_cyc = od ? P_MSP_OD_CYC : P_MSP_STD_CYC;

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_reg <= 1'b0;
      low_reg <= 1'b0;
      high_reg <= 1'b0;
      ppd_reg <= 1'b0;
      sd_reg <= 1'b0;
      cnt_reg <= 20'h0_0000;
      o_line_out <= 1'b0;
      o_line_oe <= 1'b0;
    end else if (go_reg) begin
      busy_reg <= 1'b1; // [RULE_16]
      low_reg <= 1'b1;
      high_reg <= 1'b0;
      cnt_reg <= 20'h0_0000;
      o_line_out <= 1'b0;
      o_line_oe <= 1'b1; // [RULE_12]
    end else if (low_reg) begin
      cnt_reg <= cnt_reg + 20'h0_0001;
      if (cnt_reg >= rstl_cyc - 20'h0_0001) begin
        low_reg <= 1'b0;
        high_reg <= 1'b1;
        cnt_reg <= 20'h0_0000;
        o_line_out <= cfg_reg[`SWC_CFG_APU]; // [RULE_15]
        o_line_oe <= cfg_reg[`SWC_CFG_APU]; // [RULE_15]
      end
    end else if (high_reg) begin
      cnt_reg <= cnt_reg + 20'h0_0001;
      if (cnt_reg == P_APU_CYC - 20'h0_0001) begin
        o_line_out <= 1'b0;
        o_line_oe <= 1'b0;
      end
      if (cnt_reg == si_cyc - 20'h0_0001) begin
        sd_reg <= ~line_s; // [RULE_13]
      end
      if (cnt_reg == msp_cyc - 20'h0_0001) begin
        ppd_reg <= ~line_s | cfg_reg[`SWC_CFG_PPM]; // [RULE_13] [RULE_15]
      end
      if (cnt_reg >= rsth_cyc - 20'h0_0001) begin
        high_reg <= 1'b0;
        busy_reg <= 1'b0; // [RULE_11] [RULE_16]
        o_line_out <= 1'b0;
        o_line_oe <= 1'b0;
      end
    end
  end

endmodule // swc_cmd

/* sim/swc_cmd_checker.sv */
`timescale 1ns/1ps
module swc_cmd_checker #(
  parameter int P_RSTL = 900,
  parameter int P_RSTH = 900,
  parameter int P_RSTL_OD = 8750
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_scl,
  input wire o_sda_oe,
  input wire o_line_out,
  input wire o_line_oe
);
  localparam int L_REL = 40;
  reg scl_q;
  int fall_cnt;
  int low_cnt;
  int gap_cnt;
  wire low_w = o_line_oe && !o_line_out;
  wire hi_w = o_line_oe && o_line_out;
  // Cycles since SCL fell, since low drive began, and between low starts
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_q <= 1'b1;
      fall_cnt <= 1000;
      low_cnt <= 0;
      gap_cnt <= 100000;
    end else begin
      scl_q <= i_scl;
      fall_cnt <= (scl_q && !i_scl) ? 0 : fall_cnt + 1;
      low_cnt <= low_w ? low_cnt + 1 : 0;
      gap_cnt <= $rose(low_w) ? 0 : gap_cnt + 1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_low_start;
    $rose(o_line_oe) && !o_line_out;
  endsequence
  sequence s_pulse;
    hi_w [*2] ##1 !o_line_oe;
  endsequence
  property p_low_first;
    $rose(o_line_oe) |-> !o_line_out;
  endproperty
  a_low_first: assert property (p_low_first) else $error("line drive not low first");
  property p_start_time;
    s_low_start |-> fall_cnt <= 32;
  endproperty
  a_start_time: assert property (p_start_time) else $error("line start late");
  property p_low_len;
    $fell(low_w) |-> low_cnt == P_RSTL || low_cnt == P_RSTL + 1 ||
      low_cnt == P_RSTL_OD || low_cnt == P_RSTL_OD + 1;
  endproperty
  a_low_len: assert property (p_low_len) else $error("low period length");
  property p_done;
    $fell(low_w) |-> ##[0:L_REL] !o_line_oe;
  endproperty
  a_done: assert property (p_done) else $error("line not released");
  property p_gap;
    s_low_start |-> gap_cnt >= P_RSTL + P_RSTH;
  endproperty
  a_gap: assert property (p_gap) else $error("reset started while busy");
  property p_pulse;
    $rose(hi_w) |-> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pullup pulse length");
  property p_pulse_src;
    $rose(hi_w) |-> $past(low_w);
  endproperty
  a_pulse_src: assert property (p_pulse_src) else $error("pulse not after low");
  property p_ack_scl_low;
    $changed(o_sda_oe) |-> !i_scl;
  endproperty
  a_ack_scl_low: assert property (p_ack_scl_low) else $error("data moved, clock high");
endmodule // swc_cmd_checker

bind swc_cmd swc_cmd_checker #(
  .P_RSTL(P_RSTL_STD_CYC),
  .P_RSTH(P_RSTH_STD_CYC),
  .P_RSTL_OD(P_RSTL_OD_CYC)
) i_chk (
  .i_clk(i_clk),
  .i_sys_rst(i_sys_rst),
  .i_scl(i_scl),
  .o_sda_oe(o_sda_oe),
  .o_line_out(o_line_out),
  .o_line_oe(o_line_oe)
);

/* sim/swc_host.sv */
`timescale 1ns/1ps
module swc_host #(
  parameter [6:0] P_ADDR = 7'h2A
) (
  input wire i_clk,
  input wire i_sda,
  output reg o_scl = 1'b1,
  output reg o_sda = 1'b1
);
  task tk;
    repeat (5) @(negedge i_clk);
  endtask
  task st;
    tk;
    o_sda = 1'b1;
    tk;
    o_scl = 1'b1;
    tk;
    o_sda = 1'b0;
    tk;
    o_scl = 1'b0;
  endtask
  task sp;
    tk;
    o_sda = 1'b0;
    tk;
    o_scl = 1'b1;
    tk;
    o_sda = 1'b1;
  endtask
  task bit1(input b, output r);
    tk;
    o_sda = b;
    tk;
    o_scl = 1'b1;
    tk;
    r = i_sda;
    tk;
    o_scl = 1'b0;
  endtask
  task xfer(input [7:0] w, output [7:0] r, output ack);
    reg n;
    for (int i = 7; i >= 0; i--)
      bit1(w[i], r[i]);
    bit1(1'b1, n);
    ack = !n;
  endtask
  task wr(input [7:0] c, input n, input [7:0] p, output [2:0] a);
    reg [7:0] r;
    a = 3'b000;
    st;
    xfer({P_ADDR, 1'b0}, r, a[2]);
    xfer(c, r, a[1]);
    if (n)
      xfer(p, r, a[0]);
    sp;
  endtask
  task cfg(input [3:0] c, output [2:0] a);
    wr(8'hD2, 1'b1, {~c, c}, a);
  endtask
  task rd(output [7:0] d);
    reg a;
    st;
    xfer({P_ADDR, 1'b1}, d, a);
    xfer(8'hFF, d, a);
    sp;
  endtask
  // Read status until the line is free
  task poll(output [7:0] d);
    d = 8'h01;
    for (int k = 0; k < 100 && d[0] === 1'b1; k++)
      rd(d);
  endtask
endmodule // swc_host

/* sim/swc_cmd_tb.sv */
`timescale 1ns/1ps
module swc_cmd_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg drv_low = 1'b0;
  reg [1:0] md = 2'd0;
  reg [19:0] cfgs = 20'h0_8201;
  reg [9:0] mds = 10'h049;
  integer rel = 0;
  integer failures = 0;
  integer comparisons = 0;
  reg [7:0] d;
  reg [7:0] e;
  reg [2:0] a;
  reg [3:0] c;
  wire scl, sda_h, sda_out, sda_oe, ln_out, ln_oe;
  wire sda = sda_oe ? sda_out : sda_h;
  wire ln = ln_oe ? ln_out : !drv_low;
  always #4 clk = ~clk;
  // Far device: none, presence pulse, or shorted line; pulse timing follows speed
  always @(negedge clk) begin
    rel <= ln_oe ? 0 : rel + 1;
    drv_low <= md == 2'd2 || (md == 2'd1 && (c[3] ? (rel > 150 && rel < 1500) :
               (rel > 20 && rel < 120)));
  end
  swc_host i_swc_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_h));
  swc_cmd #(
    .P_RSTL_STD_CYC(20'h0384), .P_RSTH_STD_CYC(20'h0384),
    .P_SI_STD_CYC(20'h000A), .P_MSP_STD_CYC(20'h0032), .P_APU_CYC(20'h0002)
  ) i_swc_cmd (
    .i_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_line(ln),
    .o_line_out(ln_out), .o_line_oe(ln_oe)
  );
  ////////////////////////////////////////
  task chk(input string nm, input [7:0] got, input [7:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("wrong value %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #600000;
    failures = failures + 1;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    i_swc_host.rd(d);
    chk("status", d, 8'h18);
    $display("test reset state done");
    for (int k = 0; k < 4; k++) begin
      c = 4'h1 << k;
      i_swc_host.cfg(c, a);
      chk("cfg acks", {5'h00, a}, 8'h07);
      i_swc_host.rd(d);
      chk("config", d, {4'h0, c});
    end
    i_swc_host.wr(8'hD2, 1'b1, 8'h13, a);
    chk("bad acks", {5'h00, a}, 8'h06);
    i_swc_host.rd(d);
    chk("config kept", d, 8'h08);
    $display("test config write done");
    for (int k = 0; k < 5; k++) begin
      c = cfgs[4*k +: 4];
      md = mds[2*k +: 2];
      e = {4'h0, md != 2'd2, md == 2'd2, md != 2'd0 || c[1], 1'b0};
      i_swc_host.cfg(c, a);
      i_swc_host.wr(8'hB4, 1'b0, 8'h00, a);
      chk("reset acks", {5'h00, a}, 8'h06);
      i_swc_host.rd(d);
      chk("busy", {7'h00, d[0]}, 8'h01);
      i_swc_host.wr(8'hD2, 1'b1, 8'hE1, a);
      chk("busy cfg acks", {5'h00, a}, 8'h04);
      i_swc_host.wr(8'hB4, 1'b0, 8'h00, a);
      chk("busy reset acks", {5'h00, a}, 8'h04);
      i_swc_host.poll(d);
      chk("result", d, e);
      $display("test bus reset %0d done", k);
    end
    end_of_test;
  end
endmodule // swc_cmd_tb
